/* File: verilog/sbm_pkg.sv */
// Constants and types of the serial-bus byte master.
// Assumes a byte-wide register port and an open-drain clock/data pin pair.
// Behaviour
// - Read byte valid once cycle busy clears
// - Four byte registers clear on any reset
// - Word address selects byte inside target
// - Target-address write starts one transfer
// - Bits seven to one hold slave address
// - Bit zero: write zero, read one
// - Mode bit drops the word address
// - Cycle busy flag spans software transfer
// - Load busy flag spans EEPROM download
// - Detected bit switches pins to serial
// - Detected bit set when EEPROM answers
// - Detect once per link reset release
// - No EEPROM: no load, pins return to general
// - Test bit picks serial clock rate
package sbm_pkg;
    // Register offsets and reset value
    localparam logic [7:0] OFS_DATA = 8'hB0;
    localparam logic [7:0] OFS_WORD = 8'hB1;
    localparam logic [7:0] OFS_TSEL = 8'hB2;
    localparam logic [7:0] OFS_CTRL = 8'hB3;
    localparam logic [7:0] REG_RST = 8'h00;
    // Field positions
    localparam int CS_MODE = 7;
    localparam int CS_SWBUSY = 5;
    localparam int CS_LDBUSY = 4;
    localparam int CS_DET = 3;
    localparam int CS_TEST = 0;
    localparam int TS_DIR = 0;
    // Target used for the EEPROM probe and download
    localparam logic [6:0] PROBE_SLAVE = 7'h50;
    localparam logic [7:0] PROBE_WORD = 8'h00;
    // Quarter-bit timing on the link clock
    localparam int LINK_PERIOD_PS = 15000;
    localparam int QTR_BIT_NS = 2500;
    localparam int QTR_CYC = (QTR_BIT_NS * 1000) / LINK_PERIOD_PS;
    localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
    // Two link cycles a quarter leave room for the pin flop and the data synchroniser
    localparam logic [7:0] TEST_QTR_LAST = 8'h01;
    localparam logic [3:0] LAST_BIT = 4'h8;
    // Symbol commands of the bit engine
    typedef enum logic [3:0] {
        CMD_START = 4'h1,
        CMD_STOP = 4'h2,
        CMD_WR = 4'h4,
        CMD_RD = 4'h8
    } sbm_cmd_t;
    // Transfer sequencer states
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_START = 9'h002,
        ST_ADDR_W = 9'h004,
        ST_WORD = 9'h008,
        ST_DATA_W = 9'h010,
        ST_RSTART = 9'h020,
        ST_ADDR_R = 9'h040,
        ST_DATA_R = 9'h080,
        ST_STOP = 9'h100
    } sbm_state_t;
endpackage

/* File: verilog/sbm_bit_engine.sv */
// Bit engine: one start, stop or nine-bit byte symbol per command.
// Assumes a quarter-bit tick and a synchronised data pin, all on the link clock.
`timescale 1ns/1ps
module sbm_bit_engine
    import sbm_pkg::*;
(
    // Clock and reset
    input wire logic i_link_clk,
    input wire logic i_link_rst,
    // Command side
    input wire logic i_tick,
    input wire logic i_cmd_valid,
    input wire sbm_cmd_t i_cmd,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_sda_in,
    // Result side
    output logic o_done,
    output logic o_ack_low,
    output logic [7:0] o_rx_byte,
    output logic o_scl_low,
    output logic o_sda_low
);
    sbm_cmd_t cmd_ff;
    logic busy_ff;
    logic [1:0] phase_ff;
    logic [3:0] bit_ff;
    logic nxt_scl_low;
    logic nxt_sda_low;
    logic is_byte;
    logic step;

    assign is_byte = (cmd_ff == CMD_WR) || (cmd_ff == CMD_RD);
    assign step = i_tick && busy_ff;

    // Pin levels for the current quarter of a symbol
    always_comb begin
        nxt_scl_low = (phase_ff == 2'h0) || (phase_ff == 2'h3);
        nxt_sda_low = 1'b0;
        case (cmd_ff)
            CMD_START: nxt_sda_low = phase_ff[1];
            CMD_STOP: begin
                nxt_scl_low = (phase_ff == 2'h0);
                nxt_sda_low = !phase_ff[1];
            end
            CMD_WR: nxt_sda_low = (bit_ff != LAST_BIT) && !o_rx_byte[7];
            default: nxt_sda_low = 1'b0; // Read releases data, last bit is a not-acknowledge
        endcase
    end

    // Symbol sequencing, shifting and sampling
    always_ff @(posedge i_link_clk) begin
        if (i_link_rst) begin
            cmd_ff <= CMD_START;
            busy_ff <= 1'b0;
            phase_ff <= 2'h0;
            bit_ff <= 4'h0;
            o_rx_byte <= 8'h00;
            o_done <= 1'b0;
            o_ack_low <= 1'b0;
            o_scl_low <= 1'b0;
            o_sda_low <= 1'b0;
        end else begin
            o_done <= step && (phase_ff == 2'h3) && (!is_byte || (bit_ff == LAST_BIT));
            if (i_cmd_valid && !busy_ff) begin
                cmd_ff <= i_cmd;
                busy_ff <= 1'b1;
                phase_ff <= 2'h0;
                bit_ff <= 4'h0;
                // A stop keeps the byte just received for the register side
                if (i_cmd != CMD_STOP) begin
                    o_rx_byte <= i_tx_byte;
                end
            end else if (step) begin
                o_scl_low <= nxt_scl_low;
                o_sda_low <= nxt_sda_low;
                phase_ff <= phase_ff + 2'h1;
                if ((phase_ff == 2'h2) && (cmd_ff == CMD_RD) && (bit_ff != LAST_BIT)) begin
                    o_rx_byte <= {o_rx_byte[6:0], i_sda_in};
                end
                if ((phase_ff == 2'h2) && (cmd_ff == CMD_WR) && (bit_ff == LAST_BIT)) begin
                    o_ack_low <= !i_sda_in;
                end
                if (phase_ff == 2'h3) begin
                    if (is_byte && (bit_ff != LAST_BIT)) begin
                        bit_ff <= bit_ff + 4'h1;
                        if (cmd_ff == CMD_WR) begin
                            o_rx_byte <= {o_rx_byte[6:0], 1'b0};
                        end
                    end else begin
                        busy_ff <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // sbm_bit_engine

/* File: verilog/sbm_serial_master.sv */
// Serial-bus byte master: register file on the reference clock,
// transfer sequencer, EEPROM probe and pin drive on the link clock.
// Assumes software holds the staged registers still while a transfer runs.
`timescale 1ns/1ps
module sbm_serial_master
    import sbm_pkg::*;
(
    // Clocks and resets
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_link_rst,
    input wire logic i_global_reset_pin,
    input wire logic i_link_clk,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Shared clock pin
    input wire logic i_shared_clock_pin,
    output logic o_shared_clock_pin_out,
    output logic o_shared_clock_pin_oe_n,
    // Shared data pin
    input wire logic i_shared_data_pin,
    output logic o_shared_data_pin_out,
    output logic o_shared_data_pin_oe_n,
    // Pin mode: high when the pins carry the serial bus
    output logic o_serial_mode
);
    // Reference-domain state
    logic global_reset_pin_s1_ff;
    logic global_reset_pin_s2_ff;
    logic lrst_s1_ff;
    logic lrst_s2_ff;
    logic rst_all_ff;
    logic [7:0] data_ff;
    logic [7:0] word_ff;
    logic [7:0] tsel_ff;
    logic mode_ff;
    logic test_ff;
    logic swbusy_ff;
    logic go_tgl_ff;
    logic done_s1_ff;
    logic done_s2_ff;
    logic done_s3_ff;
    logic ldb_s1_ff;
    logic ldb_s2_ff;
    logic det_s1_ff;
    logic det_s2_ff;
    logic done_evt;
    logic tsel_wr;
    // Link-domain state
    logic lr_s1_ff;
    logic lr_s2_ff;
    logic go_s1_ff;
    logic go_s2_ff;
    logic go_s3_ff;
    logic sda_s1_ff;
    logic sda_s2_ff;
    logic tst_s1_ff;
    logic tst_s2_ff;
    logic [7:0] qcnt_ff;
    sbm_state_t state_ff;
    logic issued_ff;
    logic probe_pend_ff;
    logic probe_run_ff;
    logic ldbusy_ff;
    logic det_ff;
    logic done_tgl_ff;
    logic [6:0] x_addr_ff;
    logic x_rd_ff;
    logic x_mode_ff;
    logic [7:0] x_word_ff;
    logic [7:0] x_data_ff;
    logic tick;
    logic go_evt;
    logic serial_on;
    logic cmd_valid;
    sbm_cmd_t cmd;
    logic [7:0] tx_byte;
    logic eng_done;
    logic eng_ack;
    logic [7:0] eng_rx;
    logic eng_scl_low;
    logic eng_sda_low;

    // ---------------- Reference clock domain ----------------

    // Reset pins pass two flops, then merge with the power-on reset
    always_ff @(posedge i_ref_clk) begin
        global_reset_pin_s1_ff <= i_global_reset_pin;
        global_reset_pin_s2_ff <= global_reset_pin_s1_ff;
        lrst_s1_ff <= i_link_rst;
        lrst_s2_ff <= lrst_s1_ff;
        rst_all_ff <= i_sys_rst || global_reset_pin_s2_ff || lrst_s2_ff;
    end

    assign tsel_wr = i_reg_wr && (i_reg_addr == OFS_TSEL);
    assign done_evt = done_s2_ff ^ done_s3_ff;

    // Staging registers written by software
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || rst_all_ff) begin
            word_ff <= REG_RST;
            tsel_ff <= REG_RST;
            mode_ff <= 1'b0;
            test_ff <= 1'b0;
        end else if (i_reg_wr) begin
            if (i_reg_addr == OFS_WORD) begin
                word_ff <= i_reg_wdata;
            end
            if (tsel_wr) begin
                tsel_ff <= i_reg_wdata;
            end
            if (i_reg_addr == OFS_CTRL) begin
                mode_ff <= i_reg_wdata[CS_MODE];
                test_ff <= i_reg_wdata[CS_TEST];
            end
        end
    end

    // Data byte: written by software, loaded with the byte that a read returns
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || rst_all_ff) begin
            data_ff <= REG_RST;
        end else if (done_evt && tsel_ff[TS_DIR]) begin
            data_ff <= eng_rx;
        end else if (i_reg_wr && (i_reg_addr == OFS_DATA)) begin
            data_ff <= i_reg_wdata;
        end
    end

    // Launch toggle and software-cycle busy flag
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || rst_all_ff) begin
            go_tgl_ff <= 1'b0;
            swbusy_ff <= 1'b0;
        end else if (tsel_wr) begin
            go_tgl_ff <= !go_tgl_ff;
            swbusy_ff <= 1'b1;
        end else if (done_evt) begin
            swbusy_ff <= 1'b0;
        end
    end

    // Completion toggle and status levels coming back from the link side
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
            done_s3_ff <= 1'b0;
            ldb_s1_ff <= 1'b0;
            ldb_s2_ff <= 1'b0;
            det_s1_ff <= 1'b0;
            det_s2_ff <= 1'b0;
        end else begin
            done_s1_ff <= done_tgl_ff;
            done_s2_ff <= done_s1_ff;
            done_s3_ff <= done_s2_ff;
            ldb_s1_ff <= ldbusy_ff;
            ldb_s2_ff <= ldb_s1_ff;
            det_s1_ff <= det_ff;
            det_s2_ff <= det_s1_ff;
        end
    end

    // Registered read port
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                OFS_DATA: o_reg_rdata <= data_ff;
                OFS_WORD: o_reg_rdata <= word_ff;
                OFS_TSEL: o_reg_rdata <= tsel_ff;
                OFS_CTRL: o_reg_rdata <= {mode_ff, 1'b0, swbusy_ff, ldb_s2_ff, det_s2_ff, 2'b00, test_ff};
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ---------------- Link clock domain ----------------

    // Reset, data pin and test bit each pass two flops, the launch toggle three
    always_ff @(posedge i_link_clk) begin
        lr_s1_ff <= rst_all_ff;
        lr_s2_ff <= lr_s1_ff;
        go_s1_ff <= go_tgl_ff;
        go_s2_ff <= go_s1_ff;
        go_s3_ff <= go_s2_ff;
        sda_s1_ff <= i_shared_data_pin;
        sda_s2_ff <= sda_s1_ff;
        tst_s1_ff <= test_ff;
        tst_s2_ff <= tst_s1_ff;
    end

    assign go_evt = go_s2_ff ^ go_s3_ff;
    assign tick = (qcnt_ff == 8'h00);

    // Quarter-bit divider; the test bit cuts it to two link cycles a quarter
    always_ff @(posedge i_link_clk) begin
        if (lr_s2_ff) begin
            qcnt_ff <= QTR_LAST;
        end else if (tick) begin
            qcnt_ff <= tst_s2_ff ? TEST_QTR_LAST : QTR_LAST;
        end else begin
            qcnt_ff <= qcnt_ff - 8'h01;
        end
    end

    // Symbol command and byte for the current state
    always_comb begin
        cmd = CMD_WR;
        tx_byte = {x_addr_ff, 1'b0};
        case (state_ff)
            ST_START: cmd = CMD_START;
            ST_RSTART: cmd = CMD_START;
            ST_STOP: cmd = CMD_STOP;
            ST_WORD: tx_byte = x_word_ff;
            ST_DATA_W: tx_byte = x_data_ff;
            ST_ADDR_R: tx_byte = {x_addr_ff, 1'b1};
            ST_DATA_R: cmd = CMD_RD;
            default: tx_byte = {x_addr_ff, 1'b0};
        endcase
    end

    assign cmd_valid = (state_ff != ST_IDLE) && !issued_ff;

    // Transfer sequencer
    always_ff @(posedge i_link_clk) begin
        if (lr_s2_ff) begin
            state_ff <= ST_IDLE;
            issued_ff <= 1'b0;
        end else if (state_ff == ST_IDLE) begin
            issued_ff <= 1'b0;
            if (probe_pend_ff || (go_evt && det_ff)) begin
                state_ff <= ST_START;
            end
        end else if (cmd_valid) begin
            issued_ff <= 1'b1;
        end else if (eng_done) begin
            issued_ff <= 1'b0;
            case (state_ff)
                ST_START: state_ff <= (x_rd_ff && x_mode_ff) ? ST_ADDR_R : ST_ADDR_W;
                ST_ADDR_W: state_ff <= !eng_ack ? ST_STOP : (x_mode_ff ? ST_DATA_W : ST_WORD);
                ST_WORD: state_ff <= !eng_ack ? ST_STOP : (x_rd_ff ? ST_RSTART : ST_DATA_W);
                ST_RSTART: state_ff <= ST_ADDR_R;
                ST_ADDR_R: state_ff <= !eng_ack ? ST_STOP : ST_DATA_R;
                ST_STOP: state_ff <= ST_IDLE;
                default: state_ff <= ST_STOP;
            endcase
        end
    end

    // Latched transfer parameters: probe target, or the staged registers
    always_ff @(posedge i_link_clk) begin
        if (lr_s2_ff) begin
            x_addr_ff <= 7'h00;
            x_rd_ff <= 1'b0;
            x_mode_ff <= 1'b0;
            x_word_ff <= 8'h00;
            x_data_ff <= 8'h00;
        end else if ((state_ff == ST_IDLE) && probe_pend_ff) begin
            x_addr_ff <= PROBE_SLAVE;
            x_rd_ff <= 1'b1;
            x_mode_ff <= 1'b0;
            x_word_ff <= PROBE_WORD;
        end else if ((state_ff == ST_IDLE) && go_evt) begin
            x_addr_ff <= tsel_ff[7:1];
            x_rd_ff <= tsel_ff[TS_DIR];
            x_mode_ff <= mode_ff;
            x_word_ff <= word_ff;
            x_data_ff <= data_ff;
        end
    end

    // EEPROM probe: once after each reset release, then the default download
    always_ff @(posedge i_link_clk) begin
        if (lr_s2_ff) begin
            probe_pend_ff <= 1'b1;
            probe_run_ff <= 1'b0;
            ldbusy_ff <= 1'b0;
            det_ff <= 1'b0;
        end else if ((state_ff == ST_IDLE) && probe_pend_ff) begin
            probe_pend_ff <= 1'b0;
            probe_run_ff <= 1'b1;
            ldbusy_ff <= 1'b1;
        end else if (probe_run_ff && eng_done && (state_ff == ST_ADDR_W)) begin
            det_ff <= eng_ack;
            ldbusy_ff <= eng_ack;
        end else if (probe_run_ff && eng_done && (state_ff == ST_STOP)) begin
            probe_run_ff <= 1'b0;
            ldbusy_ff <= 1'b0;
        end
    end

    // Completion toggle; a launch with the interface disabled ends at once
    always_ff @(posedge i_link_clk) begin
        if (lr_s2_ff) begin
            done_tgl_ff <= 1'b0;
        end else if (!probe_run_ff && eng_done && (state_ff == ST_STOP)) begin
            done_tgl_ff <= !done_tgl_ff;
        end else if ((state_ff == ST_IDLE) && go_evt && !det_ff && !probe_pend_ff) begin
            done_tgl_ff <= !done_tgl_ff;
        end
    end

    assign serial_on = det_ff || probe_run_ff || probe_pend_ff;

    // Open-drain pin drive; released whenever the pins are in general-purpose mode
    always_ff @(posedge i_link_clk) begin
        if (lr_s2_ff) begin
            o_shared_clock_pin_out <= 1'b0;
            o_shared_data_pin_out <= 1'b0;
            o_shared_clock_pin_oe_n <= 1'b1;
            o_shared_data_pin_oe_n <= 1'b1;
            o_serial_mode <= 1'b0;
        end else begin
            o_shared_clock_pin_oe_n <= !(serial_on && eng_scl_low);
            o_shared_data_pin_oe_n <= !(serial_on && eng_sda_low);
            o_serial_mode <= serial_on;
        end
    end

    sbm_bit_engine u_engine (
        .i_link_clk(i_link_clk),
        .i_link_rst(lr_s2_ff),
        .i_tick(tick),
        .i_cmd_valid(cmd_valid),
        .i_cmd(cmd),
        .i_tx_byte(tx_byte),
        .i_sda_in(sda_s2_ff),
        .o_done(eng_done),
        .o_ack_low(eng_ack),
        .o_rx_byte(eng_rx),
        .o_scl_low(eng_scl_low),
        .o_sda_low(eng_sda_low)
    );

    // ---------------- Checks ----------------

    a_launch_sets_busy: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (tsel_wr && !rst_all_ff) |=> swbusy_ff && (go_tgl_ff != $past(go_tgl_ff)))
        else $error("target write did not launch");
    a_busy_holds: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (swbusy_ff && !done_evt && !rst_all_ff) |=> swbusy_ff)
        else $error("cycle busy dropped early");
    a_read_byte_kept: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (done_evt && tsel_ff[TS_DIR] && !rst_all_ff) |=> (data_ff == $past(eng_rx)) && !swbusy_ff)
        else $error("read byte not loaded");
    a_regs_cleared: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        rst_all_ff |=> (data_ff == REG_RST) && (word_ff == REG_RST) && (tsel_ff == REG_RST) && !swbusy_ff)
        else $error("registers not cleared");
    a_slave_byte: assert property (@(posedge i_link_clk) disable iff (lr_s2_ff)
        (cmd_valid && (state_ff == ST_ADDR_W)) |-> (tx_byte == {x_addr_ff, 1'b0}))
        else $error("wrong address byte");
    a_word_byte: assert property (@(posedge i_link_clk) disable iff (lr_s2_ff)
        (cmd_valid && (state_ff == ST_WORD)) |-> (tx_byte == x_word_ff) && (cmd == CMD_WR))
        else $error("wrong word byte");
    a_mode_skips_word: assert property (@(posedge i_link_clk) disable iff (lr_s2_ff)
        (eng_done && !cmd_valid && (state_ff == ST_ADDR_W) && eng_ack && x_mode_ff) |=> (state_ff == ST_DATA_W))
        else $error("word address sent in short mode");
    a_read_direct: assert property (@(posedge i_link_clk) disable iff (lr_s2_ff)
        (eng_done && !cmd_valid && (state_ff == ST_START) && x_rd_ff && x_mode_ff) |=> (state_ff == ST_ADDR_R))
        else $error("short read did not address for read");
    a_probe_once: assert property (@(posedge i_link_clk) disable iff (lr_s2_ff)
        !probe_pend_ff |=> !probe_pend_ff)
        else $error("second EEPROM probe");
    a_gpio_release: assert property (@(posedge i_link_clk) disable iff (lr_s2_ff)
        !serial_on |=> o_shared_clock_pin_oe_n && o_shared_data_pin_oe_n && !o_serial_mode)
        else $error("pins driven in general-purpose mode");
endmodule // sbm_serial_master

/* File: verif/sbm_eeprom_model.sv */
// Behavioural serial EEPROM answering at the probe address.
// Assumes pulled-up wire levels on both inputs; pulls data low only.
`timescale 1ns/1ps
module sbm_eeprom_model
    import sbm_pkg::*;
(
    // Bus levels and presence
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_present,
    // Data pull-down
    output logic o_sda_low
);
    logic [7:0] mem [0:255];
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh = 8'h00;
    logic act = 1'b0;
    logic rd = 1'b0;
    logic first = 1'b0;
    logic word_set = 1'b0;
    int cnt = 0;
    // Known contents, each byte the inverse of its location
    initial begin
        o_sda_low = 1'b0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(~i);
    end
    // Start or repeated start opens a new address phase
    always @(negedge i_sda) if (i_scl === 1'b1) begin
        act = 1'b1;
        first = 1'b1;
        word_set = 1'b0;
        rd = 1'b0;
        cnt = 0;
        o_sda_low = 1'b0;
    end
    // Stop releases the bus
    always @(posedge i_sda) if (i_scl === 1'b1) act = 1'b0;
    // Count bits, shift in written bits, drop out on master refusal
    always @(posedge i_scl) if (act) begin
        cnt++;
        if (!rd && cnt <= 8) sh = {sh[6:0], i_sda};
        if (rd && cnt == 9 && i_sda) act = 1'b0;
    end
    // Drive acknowledge and read bits while the clock is low
    always @(negedge i_scl) if (act) begin
        if (cnt == 8 && !rd) begin
            o_sda_low = 1'b1;
            if (first) begin
                first = 1'b0;
                rd = sh[0];
                if (!i_present || sh[7:1] != PROBE_SLAVE) begin
                    o_sda_low = 1'b0;
                    act = 1'b0;
                end
            end else if (!word_set) begin
                ptr = sh;
                word_set = 1'b1;
            end else begin
                mem[ptr] = sh;
                ptr++;
            end
        end else if (cnt == 8) begin
            o_sda_low = 1'b0;
        end else if (cnt == 9) begin
            o_sda_low = 1'b0;
            cnt = 0;
            if (rd) begin
                sh = mem[ptr];
                ptr++;
                o_sda_low = ~sh[7];
            end
        end else if (rd && cnt >= 1 && cnt <= 7) begin
            o_sda_low = ~sh[7-cnt];
        end
    end
endmodule // sbm_eeprom_model

/* File: verif/test_sbm_serial_master.sv */
// Self-checking bench of the serial-bus byte master.
// Assumes the EEPROM model on pulled-up pins and the package's register map.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module test_sbm_serial_master;
    import sbm_pkg::*;
    logic i_ref_clk = 0, i_link_clk = 0, i_sys_rst = 1, i_link_rst = 0, glob_rst = 0;
    logic [7:0] ra = 8'h00, wd = 8'h00, o_rd;
    logic rwr = 0, rrd = 0, present = 1, slv_low;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, o_serial_mode;
    int fail_count = 0, checks_done = 0;
    // Pulled-up wire levels
    wire scl_w = scl_oe_n ? 1'b1 : scl_out;
    wire sda_w = (sda_oe_n ? 1'b1 : sda_out) & ~slv_low;
    // Clocks, link clock offset in phase
    always #12.5 i_ref_clk = ~i_ref_clk;
    initial begin
        #3.1;
        forever #7.5 i_link_clk = ~i_link_clk;
    end
    sbm_serial_master u_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_link_rst(i_link_rst),
        .i_global_reset_pin(glob_rst), .i_link_clk(i_link_clk), .i_reg_addr(ra), .i_reg_wr(rwr),
        .i_reg_rd(rrd), .i_reg_wdata(wd), .o_reg_rdata(o_rd), .i_shared_clock_pin(scl_w),
        .o_shared_clock_pin_out(scl_out), .o_shared_clock_pin_oe_n(scl_oe_n),
        .i_shared_data_pin(sda_w), .o_shared_data_pin_out(sda_out),
        .o_shared_data_pin_oe_n(sda_oe_n), .o_serial_mode(o_serial_mode));
    sbm_eeprom_model u_eep (.i_scl(scl_w), .i_sda(sda_w), .i_present(present), .o_sda_low(slv_low));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        ra = a;
        wd = d;
        rwr = 1;
        @(negedge i_ref_clk);
        rwr = 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_ref_clk);
        ra = a;
        rrd = 1;
        @(negedge i_ref_clk);
        rrd = 0;
        @(negedge i_ref_clk);
        d = o_rd;
    endtask
    // Poll a status bit until low; report polls and whether it was seen high
    task automatic wait_low(input int b, output int n, output logic seen);
        logic [7:0] v;
        n = 0;
        seen = 0;
        v = 8'hFF;
        while (v[b] !== 1'b0 && n < 20000) begin
            rd(OFS_CTRL, v);
            seen |= v[b];
            n++;
        end
        if (n >= 20000) fail_count++;
    endtask
    // Stage, launch and wait out one transfer
    task automatic xfer(input logic [7:0] c, w, d, t, output int n);
        logic seen;
        wr(OFS_CTRL, c);
        wr(OFS_DATA, d);
        wr(OFS_WORD, w);
        wr(OFS_TSEL, t);
        wait_low(CS_SWBUSY, n, seen);
        `CHK("cycle busy seen", 1'b1, seen)
    endtask
    task automatic t_regs_clear();
        logic [7:0] v;
        for (int i = 0; i < 6; i++) begin
            if (i != 3) begin
                rd(8'(OFS_DATA + i), v);
                `CHK("reg after reset", REG_RST, v)
            end
        end
    endtask
    task automatic t_probe(input logic det);
        int n;
        logic seen;
        logic [7:0] v;
        wait_low(CS_LDBUSY, n, seen);
        // A refused probe still sends its stop at the slow rate before the pins go back
        if (!det) repeat (600) @(negedge i_ref_clk);
        if (det) `CHK("load busy seen", 1'b1, seen)
        rd(OFS_CTRL, v);
        `CHK("detected", det, v[CS_DET])
        `CHK("serial mode", det, o_serial_mode)
    endtask
    task automatic t_write();
        int n;
        xfer(8'h01, 8'h12, 8'hA5, {PROBE_SLAVE, 1'b0}, n);
        `CHK("fast test clock", 1'b1, n < 100)
        `CHK("written byte", 8'hA5, u_eep.mem[8'h12])
    endtask
    task automatic t_read(input logic [7:0] c, input logic [7:0] e);
        int n;
        logic [7:0] v;
        xfer(c, 8'h12, 8'h00, {PROBE_SLAVE, 1'b1}, n);
        rd(OFS_DATA, v);
        `CHK("read byte", e, v)
    endtask
    // Short mode write: the data byte follows the address, no word address goes out
    task automatic t_short_write();
        int n;
        xfer(8'h81, 8'h00, 8'h40, {PROBE_SLAVE, 1'b0}, n);
        `CHK("short write kept", 8'hFF, u_eep.mem[8'h00])
        t_read(8'h81, 8'hBF);
    endtask
    task automatic t_nack();
        int n;
        xfer(8'h01, 8'h20, 8'h5A, {7'h33, 1'b0}, n);
        `CHK("untouched byte", 8'hDF, u_eep.mem[8'h20])
    endtask
    task automatic t_no_eeprom();
        int n;
        present = 0;
        wr(OFS_WORD, 8'h55);
        i_link_rst = 1;
        repeat (5) @(negedge i_ref_clk);
        i_link_rst = 0;
        t_regs_clear();
        t_probe(1'b0);
        present = 1;
        xfer(8'h01, 8'h30, 8'h77, {PROBE_SLAVE, 1'b0}, n);
        `CHK("no bus write", 8'hCF, u_eep.mem[8'h30])
        t_probe(1'b0);
    endtask
    task automatic t_glob_rst();
        wr(OFS_DATA, 8'h3C);
        glob_rst = 1;
        repeat (5) @(negedge i_ref_clk);
        glob_rst = 0;
        t_regs_clear();
    endtask
    task automatic results();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(negedge i_ref_clk);
        i_sys_rst = 0;
        t_regs_clear();
        t_probe(1'b1);
        t_write();
        t_read(8'h01, 8'hA5);
        t_read(8'h81, 8'hEC);
        t_short_write();
        t_nack();
        t_no_eeprom();
        t_glob_rst();
        results();
    end
    // Watchdog
    initial begin
        repeat (80000) @(posedge i_ref_clk);
        fail_count++;
        results();
    end
endmodule // test_sbm_serial_master
